//--- rtl/wws_pkg.sv
// Shared constants and types of the window watchdog supervisor
package wws_pkg;

   // Core clock rate, in kHz, used to turn times into cycle counts
   localparam int unsigned CLK_KHZ = 25000;

   // Reset hold delay after supply-good returns, nominal and limits, in ms
   localparam int unsigned HOLD_MS = 25;
   localparam int unsigned HOLD_MIN_MS = 20;
   localparam int unsigned HOLD_MAX_MS = 30;
   localparam int unsigned HOLD_CYC = HOLD_MS * CLK_KHZ;

   // Upper timeout per timeout select strap, in ms
   localparam int unsigned TOUT_LO_MS = 250;
   localparam int unsigned TOUT_HI_MS = 2500;
   // Stand-in for the capacitor-programmed timeout; plain default
   localparam int unsigned TOUT_CAP_MS = 1000;
   localparam int unsigned TOUT_LO_CYC = TOUT_LO_MS * CLK_KHZ;
   localparam int unsigned TOUT_HI_CYC = TOUT_HI_MS * CLK_KHZ;
   localparam int unsigned TOUT_CAP_CYC = TOUT_CAP_MS * CLK_KHZ;

   // Window ratios, upper over lower, scaled by ten
   localparam int unsigned RATIO_SCALE = 10;
   localparam int unsigned RATIO_N_LO_X10 = 318;
   localparam int unsigned RATIO_N_HI_X10 = 320;
   localparam int unsigned RATIO_N_CAP_X10 = 258;
   localparam int unsigned RATIO_W_LO_X10 = 1249;
   localparam int unsigned RATIO_W_HI_X10 = 1277;
   localparam int unsigned RATIO_W_CAP_X10 = 645;

   // Timeout select strap codes
   localparam logic [1:0] TSEL_LOW = 2'h0;
   localparam logic [1:0] TSEL_HIGH = 2'h1;
   localparam logic [1:0] TSEL_CAP = 2'h2;

   // Reset values of the core state
   localparam logic [31:0] CNT_RST = 32'h0;

   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_RUN = 2'b01
   } wws_state_t;

   // Strap inputs travelling together
   typedef struct packed {
      logic [1:0] timeout_select_strap;
      logic window_ratio_strap;
   } wws_strap_t;

   // Whole state of the supervisor core
   typedef struct packed {
      wws_state_t state;
      logic [31:0] hold_cnt;
      logic [31:0] win_cnt;
      logic armed;
      logic trig_prev;
      logic rst_oe;
      logic rst_o;
   } wws_core_t;

endpackage

//--- rtl/wws_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module wws_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } wws_sync_t;

   wws_sync_t s_q;
   wws_sync_t s_d;

   // First stage feeds only the second stage
   always_comb begin
      s_d.meta = d;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stable;

endmodule

//--- rtl/wws_top.sv
// Window watchdog and reset sequencer of a processor supervisor
// Summary of operation
// - No trigger before the upper timeout asserts reset for the full hold delay.
// - A watchdog reset restarts the window timing once reset releases.
// - After reset release the first window has no too-early check.
// - The first rising trigger edge after release enables the too-early check.
// - A trigger outside the window, early or late, asserts reset.
// - Supply-good false asserts reset and holds it regardless of triggers.
// - After supply-good returns, reset is held 25 ms, then released.
// - Upper timeout follows the select strap: 0.25 s, 2.5 s or capacitor value.
// - Lower boundary follows the ratio strap and the timeout strap ratios.
// - Runs on a free clock; trigger edges seen two clock cycles late, after the two flip-flop synchroniser.
`timescale 1ns/1ps
module wws_top #(
   parameter int unsigned HOLD_CYC = wws_pkg::HOLD_CYC,
   parameter int unsigned TOUT_LO_CYC = wws_pkg::TOUT_LO_CYC,
   parameter int unsigned TOUT_HI_CYC = wws_pkg::TOUT_HI_CYC,
   parameter int unsigned TOUT_CAP_CYC = wws_pkg::TOUT_CAP_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic TRIGGER_INPUT,
   input wire logic SUPPLY_GOOD_THRESHOLD,
   input wire logic [1:0] TIMEOUT_SELECT_STRAP,
   input wire logic WINDOW_RATIO_STRAP,
   output logic PROC_RST_O,
   output logic PROC_RST_OE
);

   // Lower boundaries derived from each timeout and its ratio
   localparam logic [31:0] LOW_N_LO = 32'((TOUT_LO_CYC * wws_pkg::RATIO_SCALE) / wws_pkg::RATIO_N_LO_X10);
   localparam logic [31:0] LOW_N_HI = 32'((TOUT_HI_CYC * wws_pkg::RATIO_SCALE) / wws_pkg::RATIO_N_HI_X10);
   localparam logic [31:0] LOW_N_CAP = 32'((TOUT_CAP_CYC * wws_pkg::RATIO_SCALE) / wws_pkg::RATIO_N_CAP_X10);
   localparam logic [31:0] LOW_W_LO = 32'((TOUT_LO_CYC * wws_pkg::RATIO_SCALE) / wws_pkg::RATIO_W_LO_X10);
   localparam logic [31:0] LOW_W_HI = 32'((TOUT_HI_CYC * wws_pkg::RATIO_SCALE) / wws_pkg::RATIO_W_HI_X10);
   localparam logic [31:0] LOW_W_CAP = 32'((TOUT_CAP_CYC * wws_pkg::RATIO_SCALE) / wws_pkg::RATIO_W_CAP_X10);
   localparam logic [31:0] UP_LO = 32'(TOUT_LO_CYC);
   localparam logic [31:0] UP_HI = 32'(TOUT_HI_CYC);
   localparam logic [31:0] UP_CAP = 32'(TOUT_CAP_CYC);
   localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYC - 1);

   // Reset release synchroniser
   logic [1:0] rst_sync_q;
   logic rst_n;

   // Synchronised pin inputs, and the raw strap pins
   logic trig_s;
   logic supply_ok_s;
   wws_pkg::wws_strap_t strap_raw;
   wws_pkg::wws_strap_t strap_s;

   // Window limits for the current strap setting
   logic [31:0] upper_cyc;
   logic [31:0] lower_cyc;

   // Trigger edge decode
   logic edge_any;
   logic edge_rise;
   logic too_early;
   logic timed_out;

   wws_pkg::wws_core_t c_q;
   wws_pkg::wws_core_t c_d;

   // Assert at once, release two edges later so no flop sees a runt release
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // Trigger crosses from the processor's domain
   wws_sync #(
      .W(1)
   ) u_sync_trig (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .d(TRIGGER_INPUT),
      .q(trig_s)
   );

   // Supply-good comes from the analog comparator
   wws_sync #(
      .W(1)
   ) u_sync_supply (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .d(SUPPLY_GOOD_THRESHOLD),
      .q(supply_ok_s)
   );

   assign strap_raw.timeout_select_strap = TIMEOUT_SELECT_STRAP;
   assign strap_raw.window_ratio_strap = WINDOW_RATIO_STRAP;

   // Straps are pins too; sampled continuously so a rewire takes effect
   wws_sync #(
      .W($bits(wws_pkg::wws_strap_t))
   ) u_sync_strap (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .d(strap_raw),
      .q(strap_s)
   );

   // Upper timeout and lower boundary selection
   always_comb begin
      case (strap_s.timeout_select_strap)
         wws_pkg::TSEL_HIGH: begin
            upper_cyc = UP_HI;
            lower_cyc = strap_s.window_ratio_strap ? LOW_W_HI : LOW_N_HI;
         end
         wws_pkg::TSEL_CAP: begin
            upper_cyc = UP_CAP;
            lower_cyc = strap_s.window_ratio_strap ? LOW_W_CAP : LOW_N_CAP;
         end
         wws_pkg::TSEL_LOW: begin
            upper_cyc = UP_LO;
            lower_cyc = strap_s.window_ratio_strap ? LOW_W_LO : LOW_N_LO;
         end
         default: begin
            // Unused code falls back to the short timeout, the safer choice
            upper_cyc = UP_LO;
            lower_cyc = strap_s.window_ratio_strap ? LOW_W_LO : LOW_N_LO;
         end
      endcase
   end

   // Either transition services the watchdog
   assign edge_any = trig_s ^ c_q.trig_prev;
   assign edge_rise = trig_s & ~c_q.trig_prev;
   // Early check only once armed by a rising edge
   assign too_early = edge_any & c_q.armed & (c_q.win_cnt < lower_cyc);
   // Last cycle of the window with no service in it
   assign timed_out = ~edge_any & (c_q.win_cnt >= (upper_cyc - 32'h1));

   // Next-state logic of the core
   always_comb begin
      c_d = c_q;
      // Edge history always follows the pin, so release never sees a stale edge
      c_d.trig_prev = trig_s;
      c_d.rst_o = 1'b0;
      case (c_q.state)
         wws_pkg::ST_HOLD: begin
            c_d.rst_oe = 1'b1;
            c_d.win_cnt = wws_pkg::CNT_RST;
            c_d.armed = 1'b0;
            if (!supply_ok_s) begin
               // Delay restarts on every dip of the supply
               c_d.hold_cnt = wws_pkg::CNT_RST;
            end else if (c_q.hold_cnt >= HOLD_LAST) begin
               c_d.hold_cnt = wws_pkg::CNT_RST;
               c_d.state = wws_pkg::ST_RUN;
               c_d.rst_oe = 1'b0;
            end else begin
               c_d.hold_cnt = c_q.hold_cnt + 32'h1;
            end
         end
         wws_pkg::ST_RUN: begin
            c_d.rst_oe = 1'b0;
            c_d.hold_cnt = wws_pkg::CNT_RST;
            if (!supply_ok_s) begin
               // Supply loss overrides any trigger activity
               c_d.state = wws_pkg::ST_HOLD;
               c_d.rst_oe = 1'b1;
            end else if (too_early || timed_out) begin
               c_d.state = wws_pkg::ST_HOLD;
               c_d.rst_oe = 1'b1;
            end else if (edge_any) begin
               // Valid service opens a fresh window
               c_d.win_cnt = wws_pkg::CNT_RST;
               if (edge_rise) begin
                  c_d.armed = 1'b1;
               end
            end else begin
               c_d.win_cnt = c_q.win_cnt + 32'h1;
            end
         end
         default: begin
            // Illegal state recovers through a full reset hold
            c_d.state = wws_pkg::ST_HOLD;
            c_d.rst_oe = 1'b1;
            c_d.hold_cnt = wws_pkg::CNT_RST;
            c_d.win_cnt = wws_pkg::CNT_RST;
            c_d.armed = 1'b0;
         end
      endcase
   end

   // Core state register; reset starts in hold with the output driven low
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         c_q.state <= wws_pkg::ST_HOLD;
         c_q.hold_cnt <= wws_pkg::CNT_RST;
         c_q.win_cnt <= wws_pkg::CNT_RST;
         c_q.armed <= 1'b0;
         c_q.trig_prev <= 1'b0;
         c_q.rst_oe <= 1'b1;
         c_q.rst_o <= 1'b0;
      end else begin
         c_q <= c_d;
      end
   end

   // Open-drain reset pin: driven low while enabled, pulled up otherwise
   assign PROC_RST_O = c_q.rst_o;
   assign PROC_RST_OE = c_q.rst_oe;

endmodule

//--- tb/wws_monitor.sv
// Pin-level checks of the window watchdog supervisor
`timescale 1ns/1ps
module wws_monitor #(
   parameter int unsigned HOLD_CYC = 50,
   parameter int unsigned TOUT_LO_CYC = 3200,
   parameter int unsigned TOUT_HI_CYC = 6400,
   parameter int unsigned TOUT_CAP_CYC = 2580
) (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic TRIGGER_INPUT,
   input wire logic SUPPLY_GOOD_THRESHOLD,
   input wire logic [1:0] TIMEOUT_SELECT_STRAP,
   input wire logic WINDOW_RATIO_STRAP,
   input wire logic PROC_RST_O,
   input wire logic PROC_RST_OE
);
   logic [31:0] hcnt_q;
   logic [31:0] tcnt_q;
   logic [31:0] up;
   logic trig_q;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // Upper timeout of the present strap; straps only move while reset is held
   assign up = (TIMEOUT_SELECT_STRAP == 2'h1) ? TOUT_HI_CYC :
      (TIMEOUT_SELECT_STRAP == 2'h2) ? TOUT_CAP_CYC : TOUT_LO_CYC;
   // Age of the hold and of the last pin edge; pin ages run ahead of the synchroniser
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hcnt_q <= 32'h0;
         tcnt_q <= 32'h0;
         trig_q <= 1'b0;
      end else begin
         hcnt_q <= (PROC_RST_OE && SUPPLY_GOOD_THRESHOLD) ? hcnt_q + 32'h1 : 32'h0;
         tcnt_q <= (PROC_RST_OE || TRIGGER_INPUT != trig_q) ? 32'h0 : tcnt_q + 32'h1;
         trig_q <= TRIGGER_INPUT;
      end
   end
   data_low_a: assert property (PROC_RST_O == 1'b0)
      else $error("reset data line not low");
   supply_hold_a: assert property (!SUPPLY_GOOD_THRESHOLD [*3] |=> PROC_RST_OE)
      else $error("reset not held with supply low");
   supply_fall_a: assert property ($fell(SUPPLY_GOOD_THRESHOLD) |-> ##[1:3] PROC_RST_OE)
      else $error("reset late after supply drop");
   hold_entry_a: assert property ($rose(SUPPLY_GOOD_THRESHOLD) |-> PROC_RST_OE [*8])
      else $error("reset released too soon after supply");
   hold_short_a: assert property ($fell(PROC_RST_OE) |-> hcnt_q >= HOLD_CYC)
      else $error("reset hold too short");
   hold_long_a: assert property (PROC_RST_OE && SUPPLY_GOOD_THRESHOLD |-> hcnt_q <= HOLD_CYC + 6)
      else $error("reset hold too long");
   tout_max_a: assert property (!PROC_RST_OE |-> tcnt_q <= up + 32'h6)
      else $error("no reset after upper timeout");
   rst_cause_a: assert property ($rose(PROC_RST_OE) |->
      tcnt_q < 32'h6 || tcnt_q + 32'h3 >= up || !$past(SUPPLY_GOOD_THRESHOLD, 3))
      else $error("reset without a cause");
endmodule
bind wws_top wws_monitor #(.HOLD_CYC(HOLD_CYC), .TOUT_LO_CYC(TOUT_LO_CYC), .TOUT_HI_CYC(TOUT_HI_CYC),
   .TOUT_CAP_CYC(TOUT_CAP_CYC)) mon_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .TRIGGER_INPUT(TRIGGER_INPUT),
   .SUPPLY_GOOD_THRESHOLD(SUPPLY_GOOD_THRESHOLD), .TIMEOUT_SELECT_STRAP(TIMEOUT_SELECT_STRAP),
   .WINDOW_RATIO_STRAP(WINDOW_RATIO_STRAP), .PROC_RST_O(PROC_RST_O), .PROC_RST_OE(PROC_RST_OE));

//--- tb/wws_proc_model.sv
// Supervised processor model driving the trigger pin
`timescale 1ns/1ps
module wws_proc_model (
   input wire logic clk,
   input wire logic kick,
   output logic trg
);
   initial trg = 1'b0;
   // One toggle per request; either direction is a service
   always @(negedge clk) begin
      if (kick) begin
         trg <= ~trg;
      end
   end
endmodule

//--- tb/window_watchdog_supervisor_test.sv
// Self-checking bench of the window watchdog supervisor
`timescale 1ns/1ps
module window_watchdog_supervisor_test;
   typedef struct packed {logic v; logic [31:0] a; logic [31:0] b;} wws_ev_t;
   localparam int unsigned HOLD = 50;
   localparam int unsigned TLO = 3200;
   localparam int unsigned THI = 6400;
   localparam int unsigned TCAP = 2580;
   logic clk, rst_n, sup, wr, kick, trg, rst_o, rst_oe, oe_prev;
   logic [1:0] ts;
   int cyc, error_cnt, tests_run, up, lo, r, m;
   wws_ev_t evq[$];
   wws_ev_t e;
   wws_proc_model proc_u (.clk(clk), .kick(kick), .trg(trg));
   wws_top #(.HOLD_CYC(HOLD), .TOUT_LO_CYC(TLO), .TOUT_HI_CYC(THI), .TOUT_CAP_CYC(TCAP)) dut_u (
      .CORE_CLK(clk), .RESET_N(rst_n), .TRIGGER_INPUT(trg), .SUPPLY_GOOD_THRESHOLD(sup),
      .TIMEOUT_SELECT_STRAP(ts), .WINDOW_RATIO_STRAP(wr), .PROC_RST_O(rst_o), .PROC_RST_OE(rst_oe));
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Note a reset pin edge due between dly and dly+8 cycles from now
   task automatic expect_ev(logic v, int dly);
      evq.push_back({v, 32'(cyc + dly), 32'(cyc + dly + 8)});
   endtask
   task automatic pulse(int gap);
      repeat (gap) @(negedge clk);
      kick <= 1'b1;
      @(negedge clk);
      kick <= 1'b0;
   endtask
   task automatic wait_q(int n);
      for (int i = 0; i < n && evq.size() > 0; i++) @(negedge clk);
   endtask
   task automatic end_of_test;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Compare every reset pin edge with the oldest note; falling edge so outputs have settled
   always @(negedge clk) begin
      cyc <= cyc + 1;
      oe_prev <= rst_oe;
      if (rst_n && rst_oe !== oe_prev) begin
         check("reset data", rst_o, 1'b0);
         if (evq.size() == 0) begin
            check("unexpected reset edge", rst_oe, oe_prev);
         end else begin
            e = evq.pop_front();
            check("reset level", rst_oe, e.v);
            check("reset edge time", cyc >= e.a && cyc <= e.b, 1'b1);
         end
      end
   end
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Cuts a hang short well past the expected run length
   initial begin
      repeat (95000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      {rst_n, sup, wr, kick, ts} = '0;
      oe_prev = 1'b1;
      cyc = 0;
      error_cnt = 0;
      tests_run = 0;
      void'($urandom(32'hb85814ae));
      repeat (2) @(negedge clk);
      rst_n <= 1'b1;
      // Every strap combination, spare code included: supply cycle, early edge, good services, timeout
      for (int i = 0; i < 8; i++) begin
         m = i / 2;
         sup <= 1'b0;
         if (i > 0) expect_ev(1'b1, 0);
         repeat (6) @(negedge clk);
         ts <= 2'(m);
         wr <= i[0];
         up = (m == 1) ? THI : (m == 2) ? TCAP : TLO;
         r = (m == 1) ? wws_pkg::RATIO_N_HI_X10 : (m == 2) ? wws_pkg::RATIO_N_CAP_X10 : wws_pkg::RATIO_N_LO_X10;
         if (i[0]) begin
            r = (m == 1) ? wws_pkg::RATIO_W_HI_X10 : (m == 2) ? wws_pkg::RATIO_W_CAP_X10 : wws_pkg::RATIO_W_LO_X10;
         end
         lo = up * wws_pkg::RATIO_SCALE / r;
         @(negedge clk);
         sup <= 1'b1;
         expect_ev(1'b0, HOLD);
         wait_q(HOLD + 20);
         pulse(lo / 2);
         pulse(lo / 2);
         expect_ev(1'b1, 0);
         expect_ev(1'b0, HOLD);
         wait_q(HOLD + 20);
         pulse(lo / 2);
         // Spread kept to half the window so eight rounds stay well inside the watchdog span
         repeat (3) pulse(lo + 8 + $urandom_range((up - lo) / 2));
         expect_ev(1'b1, up);
         expect_ev(1'b0, up + HOLD);
         wait_q(up + HOLD + 20);
      end
      check("pending notes", evq.size(), 0);
      end_of_test();
   end
endmodule
